// ---- dmr_pkg.sv ----
// dmr_pkg: shared types and constants for the data move and return execution block
// assumes a 14-bit instruction word as delivered by the core decoder
package dmr_pkg;
    localparam int DATA_W = 8;                 // data path width
    localparam int ADDR_W = 7;                 // file register address width
    localparam int PC_W = 13;                  // program counter width
    localparam int INSN_W = 14;                // instruction word width
    localparam logic [7:0] ACC_RST = 8'h00;    // accumulator after reset
    localparam logic [6:0] OPC_COPY = 7'h08;   // copy file register, bits 13:8 = 001000
    localparam logic [5:0] OPC_COPY6 = 6'h08;  // copy opcode upper six bits
    localparam logic [6:0] OPC_STORE = 7'h01;  // store accumulator, bits 13:7 = 0000001
    localparam logic [3:0] OPC_LIT4 = 4'hC;    // load literal, bits 13:10 = 1100
    localparam logic [3:0] OPC_RETL4 = 4'hD;   // literal return, bits 13:10 = 1101
    localparam logic [13:0] OPC_IRET = 14'h0009; // interrupt return, full word
    localparam int D_BIT = 7;                  // destination select bit position

    // one-hot execution state
    typedef enum logic [1:0] {
        DMR_RUN = 2'h1,   // normal single-cycle execution
        DMR_FILL = 2'h2   // refill cycle after a literal return
    } dmr_state_e;

    // register file write request
    typedef struct packed {
        logic we;                  // write strobe
        logic [6:0] addr;          // target address
        logic [7:0] data;          // write data
    } dmr_fwr_s;

    // complete module state
    typedef struct packed {
        dmr_state_e st;            // execution state
        logic [7:0] acc;           // accumulator
        logic [6:0] raddr;         // file read address
        dmr_fwr_s fwr;             // file write request
        logic z_we;                // zero flag write strobe
        logic z_val;               // zero flag value
        logic pc_ld;               // program counter load strobe
        logic [12:0] pc_val;       // program counter load value
        logic pop;                 // stack pop strobe
        logic gie_set;             // global_irq_enable set strobe
        logic stall;               // fetch stall during refill
    } dmr_state_s;
endpackage : dmr_pkg

// ---- dmr_exec.sv ----
// dmr_exec: executes copy, store, load literal and both returns
// assumes file read data is combinational from file_rdata_i for insn_i[6:0] decode
// assumes insn_i is valid when insn_vld_i is high and stack_top_i is the current top
// Function
// - copy reads file, writes accumulator or file
// - copy updates zero flag either destination
// - load literal into accumulator, flags kept
// - store writes accumulator to addressed file
// - interrupt return pops stack, sets enable
// - literal return loads accumulator and pc
// - literal return takes two cycles
`timescale 1ns/10ps
module dmr_exec (
    input wire logic clk_i,                     // 250 MHz core clock
    input wire logic srst_i,                    // synchronous reset, active high
    input wire logic insn_vld_i,                // instruction valid this cycle
    input wire logic [13:0] insn_i,             // instruction word
    input wire logic [7:0] file_rdata_i,        // read data of the addressed file register
    input wire logic [12:0] stack_top_i,        // stack_top return address
    output logic [7:0] acc_o,                   // accumulator value
    output logic [6:0] file_raddr_o,            // file read address (insn field)
    output logic file_we_o,                     // file write strobe
    output logic [6:0] file_waddr_o,            // file write address
    output logic [7:0] file_wdata_o,            // file write data
    output logic z_we_o,                        // zero flag write strobe
    output logic z_o,                           // zero flag value
    output logic pc_ld_o,                       // program counter load strobe
    output logic [12:0] pc_o,                   // program counter load value
    output logic pop_o,                         // stack pop strobe
    output logic gie_set_o,                     // global_irq_enable set strobe
    output logic stall_o                        // fetch stall, refill cycle
);
    dmr_pkg::dmr_state_s r;      // registered state
    dmr_pkg::dmr_state_s next_r; // next state

    // decoded op classes, combinational from the instruction field
    logic is_copy;       // copy_file_reg_op
    logic is_store;      // store_accum_op
    logic is_lit;        // load_literal_op
    logic is_iret;       // interrupt_return_op
    logic is_retl;       // literal_return_op
    logic d_sel;         // destination bit
    logic run;           // instruction accepted this cycle

    // decode; instructions presented during the refill cycle are ignored
    always_comb begin
        run = insn_vld_i && (r.st == dmr_pkg::DMR_RUN);
        d_sel = insn_i[dmr_pkg::D_BIT];
        is_copy = run && (insn_i[13:8] == dmr_pkg::OPC_COPY6);
        is_store = run && (insn_i[13:7] == dmr_pkg::OPC_STORE);
        is_lit = run && (insn_i[13:10] == dmr_pkg::OPC_LIT4);
        is_iret = run && (insn_i == dmr_pkg::OPC_IRET);
        is_retl = run && (insn_i[13:10] == dmr_pkg::OPC_RETL4);
    end

    // read address output is the registered copy of the operand field, one cycle behind insn_i
    assign file_raddr_o = r.raddr;

    // next state: strobes default low every cycle
    always_comb begin
        next_r = r;
        next_r.fwr.we = 1'b0;
        next_r.z_we = 1'b0;
        next_r.pc_ld = 1'b0;
        next_r.pop = 1'b0;
        next_r.gie_set = 1'b0;
        next_r.stall = 1'b0;
        next_r.raddr = insn_i[6:0];
        case (r.st)
            dmr_pkg::DMR_RUN: begin
                if (is_copy) begin
                    if (d_sel) begin
                        next_r.fwr.we = 1'b1;
                        next_r.fwr.addr = insn_i[6:0];
                        next_r.fwr.data = file_rdata_i;
                    end else begin
                        next_r.acc = file_rdata_i;
                    end
                    next_r.z_we = 1'b1;
                    next_r.z_val = (file_rdata_i == 8'h00);
                end else if (is_store) begin
                    next_r.fwr.we = 1'b1;
                    next_r.fwr.addr = insn_i[6:0];
                    next_r.fwr.data = r.acc;
                end else if (is_lit) begin
                    next_r.acc = insn_i[7:0];
                end else if (is_iret) begin
                    next_r.pc_ld = 1'b1;
                    next_r.pc_val = stack_top_i;
                    next_r.pop = 1'b1;
                    next_r.gie_set = 1'b1;
                end else if (is_retl) begin
                    next_r.acc = insn_i[7:0];
                    next_r.pc_ld = 1'b1;
                    next_r.pc_val = stack_top_i;
                    next_r.pop = 1'b1;
                    next_r.stall = 1'b1;
                    next_r.st = dmr_pkg::DMR_FILL;
                end
            end
            dmr_pkg::DMR_FILL: begin
                // refill cycle done; back to normal issue
                next_r.st = dmr_pkg::DMR_RUN;
            end
            default: begin
                // illegal encoding recovers to run
                next_r.st = dmr_pkg::DMR_RUN;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            r <= '0;
            r.st <= dmr_pkg::DMR_RUN;
            r.acc <= dmr_pkg::ACC_RST;
        end else begin
            r <= next_r;
        end
    end

    // outputs straight from state flops
    assign acc_o = r.acc;
    assign file_we_o = r.fwr.we;
    assign file_waddr_o = r.fwr.addr;
    assign file_wdata_o = r.fwr.data;
    assign z_we_o = r.z_we;
    assign z_o = r.z_val;
    assign pc_ld_o = r.pc_ld;
    assign pc_o = r.pc_val;
    assign pop_o = r.pop;
    assign gie_set_o = r.gie_set;
    assign stall_o = r.stall;

    // checks
    a_copy_zero_flag: assert property (@(posedge clk_i) disable iff (srst_i)
        is_copy |=> (z_we_o && (z_o == ($past(file_rdata_i) == 8'h00))))
        else $error("copy did not set zero flag from moved value");
    a_copy_dest_acc: assert property (@(posedge clk_i) disable iff (srst_i)
        (is_copy && !d_sel) |=> (acc_o == $past(file_rdata_i) && !file_we_o))
        else $error("copy to accumulator wrong");
    a_copy_dest_file: assert property (@(posedge clk_i) disable iff (srst_i)
        (is_copy && d_sel) |=> (file_we_o && z_we_o && file_wdata_o == $past(file_rdata_i)))
        else $error("copy back to file wrong");
    a_lit_no_flag: assert property (@(posedge clk_i) disable iff (srst_i)
        is_lit |=> (acc_o == $past(insn_i[7:0]) && !z_we_o))
        else $error("load literal wrong");
    a_store_write: assert property (@(posedge clk_i) disable iff (srst_i)
        is_store |=> (file_we_o && file_wdata_o == $past(acc_o) && !z_we_o))
        else $error("store accumulator wrong");
    a_iret_pop: assert property (@(posedge clk_i) disable iff (srst_i)
        is_iret |=> (pop_o && gie_set_o && pc_ld_o && pc_o == $past(stack_top_i)
            && !z_we_o && !file_we_o))
        else $error("interrupt return wrong");
    a_retl_load: assert property (@(posedge clk_i) disable iff (srst_i)
        is_retl |=> (acc_o == $past(insn_i[7:0]) && pc_ld_o && pop_o && !gie_set_o
            && pc_o == $past(stack_top_i) && !z_we_o && !file_we_o))
        else $error("literal return wrong");
    sequence s_retl_fill;
        stall_o ##1 !stall_o;
    endsequence
    a_retl_two_cycle: assert property (@(posedge clk_i) disable iff (srst_i)
        is_retl |=> s_retl_fill)
        else $error("literal return not two cycles");

    // refill cycle swallows the instruction
    // the word on the instruction bus during refill belongs to the old fetch
    // stream; letting it through would execute a word the program never reached
    sequence s_fill_cycle;
        r.st == dmr_pkg::DMR_FILL;
    endsequence
    // no strobe at all and the accumulator left alone
    sequence s_no_effect;
        !file_we_o && !z_we_o && !pc_ld_o && !pop_o
            && !gie_set_o && !stall_o && $stable(acc_o);
    endsequence
    a_fill_ignore: assert property (@(posedge clk_i) disable iff (srst_i)
        s_fill_cycle |=> s_no_effect)
        else $error("instruction taken during refill cycle");

    // an idle cycle must not disturb the core; a stray strobe here would
    // corrupt a file register or the stack without any instruction behind it
    a_idle_quiet: assert property (@(posedge clk_i) disable iff (srst_i)
        !insn_vld_i |=> s_no_effect)
        else $error("output activity without an instruction");

    // copy back aims at its own operand
    a_copy_waddr: assert property (@(posedge clk_i) disable iff (srst_i)
        (is_copy && d_sel) |=> (file_waddr_o == $past(insn_i[6:0])))
        else $error("copy write address wrong");

    a_store_waddr: assert property (@(posedge clk_i) disable iff (srst_i)
        is_store |=> (file_waddr_o == $past(insn_i[6:0]) && !pc_ld_o
            && acc_o == $past(acc_o)))
        else $error("store write address wrong");

    // only interrupt return enables
    // any other source of this strobe would open interrupts behind software's back
    a_gie_source: assert property (@(posedge clk_i) disable iff (srst_i)
        gie_set_o |-> $past(is_iret))
        else $error("interrupt enable set without interrupt return");

    a_stall_source: assert property (@(posedge clk_i) disable iff (srst_i)
        stall_o |-> $past(is_retl))
        else $error("fetch stall without literal return");

    // zero strobe only from copy
    // load literal, store and both returns leave the flags untouched
    a_zero_source: assert property (@(posedge clk_i) disable iff (srst_i)
        z_we_o |-> $past(is_copy))
        else $error("zero flag written by a non-copy instruction");

    // a reset edge clears every strobe and the accumulator; no disable here,
    // since this is exactly the cycle the others leave unwatched
    a_reset_clear: assert property (@(posedge clk_i)
        srst_i |=> (acc_o == dmr_pkg::ACC_RST && !file_we_o && !z_we_o && !pc_ld_o
            && !pop_o && !gie_set_o && !stall_o))
        else $error("outputs not cleared by reset");
endmodule : dmr_exec

// ---- tb_top.sv ----
// tb_top: self-checking bench for the data move and return execution block
// assumes file read data is supplied combinationally from the bench for insn_i[6:0]
`timescale 1ns/10ps
module tb_top;
    typedef struct packed {
        logic [13:0] insn; // instruction word
        logic [7:0] rd;    // file read data
        logic [12:0] stack_top;  // stack top
        logic [7:0] acc;   // expected accumulator
        logic [5:0] stb;   // expected strobes we, zwe, pcld, pop, gie, stall
        logic z;           // expected zero value when written
        logic [6:0] wa;    // expected write address
        logic [7:0] wd;    // expected write data
        logic [12:0] pc;   // expected pc load value
    } dmr_row_s;
    logic clk_i, srst_i, insn_vld_i, file_we_o, z_we_o, z_o, pc_ld_o, pop_o, gie_set_o, stall_o;
    logic [13:0] insn_i;
    logic [7:0] file_rdata_i, acc_o, file_wdata_o;
    logic [12:0] stack_top_i, pc_o;
    logic [6:0] file_raddr_o, file_waddr_o;
    logic [5:0] stb;
    dmr_row_s rows [10];
    int miscompares = 0;
    int check_count = 0;
    assign stb = {file_we_o, z_we_o, pc_ld_o, pop_o, gie_set_o, stall_o};
    dmr_exec u_dut (.clk_i(clk_i), .srst_i(srst_i), .insn_vld_i(insn_vld_i), .insn_i(insn_i),
        .file_rdata_i(file_rdata_i), .stack_top_i(stack_top_i), .acc_o(acc_o),
        .file_raddr_o(file_raddr_o), .file_we_o(file_we_o), .file_waddr_o(file_waddr_o),
        .file_wdata_o(file_wdata_o), .z_we_o(z_we_o), .z_o(z_o), .pc_ld_o(pc_ld_o),
        .pc_o(pc_o), .pop_o(pop_o), .gie_set_o(gie_set_o), .stall_o(stall_o));
    // 250 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // one comparison, counted; a mismatch is reported at once
    task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // present one instruction and step past its taking edge
    task automatic issue(input logic [13:0] insn, input logic [7:0] rd, input logic [12:0] stack_top);
        insn_i = insn;
        file_rdata_i = rd;
        stack_top_i = stack_top;
        insn_vld_i = 1'b1;
        @(posedge clk_i);
        #1;
    endtask : issue
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done
    initial begin
        srst_i = 1'b1;
        insn_vld_i = 1'b0;
        insn_i = 14'h0000;
        file_rdata_i = 8'h00;
        stack_top_i = 13'h0000;
        // rows run back to back; z, address, data and pc only compared with their strobes
        rows[0] = '{14'h30A5, 8'h00, 13'h0000, 8'hA5, 6'h00, 1'b0, 7'h00, 8'h00, 13'h0000};
        rows[1] = '{14'h00FF, 8'h00, 13'h0000, 8'hA5, 6'h20, 1'b0, 7'h7F, 8'hA5, 13'h0000};
        rows[2] = '{14'h0800, 8'h00, 13'h0000, 8'h00, 6'h10, 1'b1, 7'h00, 8'h00, 13'h0000};
        rows[3] = '{14'h08FF, 8'h3C, 13'h0000, 8'h00, 6'h30, 1'b0, 7'h7F, 8'h3C, 13'h0000};
        rows[4] = '{14'h30FF, 8'h00, 13'h0000, 8'hFF, 6'h00, 1'b0, 7'h00, 8'h00, 13'h0000};
        rows[5] = '{14'h0805, 8'h80, 13'h0000, 8'h80, 6'h10, 1'b0, 7'h00, 8'h00, 13'h0000};
        rows[6] = '{14'h0880, 8'h00, 13'h0000, 8'h80, 6'h30, 1'b1, 7'h00, 8'h00, 13'h0000};
        rows[7] = '{14'h0009, 8'h00, 13'h1ABC, 8'h80, 6'h0E, 1'b0, 7'h00, 8'h00, 13'h1ABC};
        rows[8] = '{14'h0080, 8'h00, 13'h0000, 8'h80, 6'h20, 1'b0, 7'h00, 8'h80, 13'h0000};
        rows[9] = '{14'h3300, 8'h00, 13'h0000, 8'h00, 6'h00, 1'b0, 7'h00, 8'h00, 13'h0000};
        repeat (8) @(posedge clk_i);
        #1;
        srst_i = 1'b0;
        chk("acc after reset", 13'h0000, {5'h00, acc_o});
        chk("strobes after reset", 13'h0000, {7'h00, stb});
        // one idle edge after release: nothing may move
        @(posedge clk_i);
        #1;
        chk("acc idle", 13'h0000, {5'h00, acc_o});
        chk("strobes idle", 13'h0000, {7'h00, stb});
        // table of ordinary cases
        foreach (rows[i]) begin
            issue(rows[i].insn, rows[i].rd, rows[i].stack_top);
            chk("acc", {5'h00, rows[i].acc}, {5'h00, acc_o});
            chk("strobes", {7'h00, rows[i].stb}, {7'h00, stb});
            chk("raddr", {6'h00, rows[i].insn[6:0]}, {6'h00, file_raddr_o});
            if (rows[i].stb[4]) chk("zero", {12'h000, rows[i].z}, {12'h000, z_o});
            if (rows[i].stb[5]) begin
                chk("waddr", {6'h00, rows[i].wa}, {6'h00, file_waddr_o});
                chk("wdata", {5'h00, rows[i].wd}, {5'h00, file_wdata_o});
            end
            if (rows[i].stb[3]) chk("pc", rows[i].pc, pc_o);
        end
        // literal return with a literal load pressed into its refill cycle
        issue(14'h34C3, 8'h00, 13'h0123);
        chk("ret acc", 13'h00C3, {5'h00, acc_o});
        chk("ret strobes", 13'h000D, {7'h00, stb});
        chk("ret pc", 13'h0123, pc_o);
        issue(14'h3011, 8'h00, 13'h0000);
        chk("refill acc", 13'h00C3, {5'h00, acc_o});
        chk("refill strobes", 13'h0000, {7'h00, stb});
        issue(14'h3042, 8'h00, 13'h0000);
        chk("after refill acc", 13'h0042, {5'h00, acc_o});
        // second reset in mid-run, straight after a copy back to its file
        issue(14'h0880, 8'h00, 13'h0000);
        chk("copy strobes", 13'h0030, {7'h00, stb});
        insn_vld_i = 1'b0;
        srst_i = 1'b1;
        @(posedge clk_i);
        #1;
        chk("acc in reset", 13'h0000, {5'h00, acc_o});
        chk("strobes in reset", 13'h0000, {7'h00, stb});
        srst_i = 1'b0;
        // the first instruction straight after release must be taken
        issue(14'h0805, 8'h5A, 13'h0000);
        chk("acc after release", 13'h005A, {5'h00, acc_o});
        chk("zero after release", 13'h0000, {12'h000, z_o});
        // reset landing in a refill cycle must leave the block ready to issue
        issue(14'h3455, 8'h00, 13'h0456);
        srst_i = 1'b1;
        @(posedge clk_i);
        #1;
        chk("strobes in fill reset", 13'h0000, {7'h00, stb});
        srst_i = 1'b0;
        issue(14'h3077, 8'h00, 13'h0000);
        chk("acc after fill reset", 13'h0077, {5'h00, acc_o});
        test_done();
    end
endmodule : tb_top
